// File: core/tx_fifo.sv
// small first-in first-out buffer for outgoing messages
`timescale 1ns/10ps
module tx_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  assign o_in_ready = (count_r != DEPTH_C);
  assign o_out_valid = (count_r != '0);
  // head word comes straight off the storage flops
  assign o_out_data = mem_r[rd_ptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end
endmodule

// File: core/wheel_state_seq.sv
// operating-state sequencer of a tyre pressure and temperature wheel sensor
// What this block does
// - starts in storage after reset and stays until pressure moves it
// - storage only samples pressure once every 240 seconds
// - storage: at or below 55 psi stays, above goes to initial
// - storage sends nothing except one message per magnet sweep
// - initial samples pressure once every second
// - initial: at or below 55 psi after 120 seconds returns to storage
// - initial: above 55 psi for more than 120 seconds goes to normal
// - normal never goes back to initial or storage
// - normal samples pressure every 3 seconds, temperature every 6
// - normal sends readings every 4 minutes
// - normal: pressure change above 1.5 psi sends at once
// - normal: change above 8 psi within 4 minutes enters burst
// - burst samples pressure every second and temperature every 2 seconds, and sends both every second
// - burst lasts 20 seconds after the last change above 8 psi, then returns to normal
// - temperature taken on every second pressure sample in all states
// - each message carries pressure and temperature together
`timescale 1ns/10ps
module wheel_state_seq
  import wheel_seq_pkg::*;
#(
  parameter int TICK_CYCLES_P = wheel_seq_pkg::TICK_CYCLES,
  parameter int PRESS_W_P = wheel_seq_pkg::PRESS_W,
  parameter int TEMP_W_P = wheel_seq_pkg::TEMP_W,
  parameter int FIFO_DEPTH_P = wheel_seq_pkg::TX_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  output logic o_press_req,
  input wire logic i_press_valid,
  input wire logic [PRESS_W_P-1:0] i_press_data,
  output logic o_temp_req,
  input wire logic i_temp_valid,
  input wire logic [TEMP_W_P-1:0] i_temp_data,
  input wire logic i_magnet,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [PRESS_W_P+TEMP_W_P-1:0] o_tx_data,
  output wheel_seq_pkg::op_state_t o_state
);
  import wheel_seq_pkg::*;

  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES_P - 1);
  localparam int MSG_W = PRESS_W_P + TEMP_W_P;
  localparam logic [PRESS_W_P-1:0] THR = PRESS_W_P'(STORE_THR_DPSI);
  localparam logic [PRESS_W_P-1:0] TX_D = PRESS_W_P'(TX_DELTA_DPSI);
  localparam logic [PRESS_W_P-1:0] BURST_D = PRESS_W_P'(BURST_DELTA_DPSI);

  op_state_t state_r, state_nxt;
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [SEC_W-1:0] sec_cnt_r, sec_cnt_nxt;
  logic [SEC_W-1:0] samp_cnt_r, samp_cnt_nxt;
  logic [SEC_W-1:0] win_cnt_r, win_cnt_nxt;
  logic [PRESS_W_P-1:0] press_r, press_nxt;
  logic [PRESS_W_P-1:0] ref_r, ref_nxt;
  logic [PRESS_W_P-1:0] last_tx_r, last_tx_nxt;
  logic [TEMP_W_P-1:0] temp_r, temp_nxt;
  logic parity_r, parity_nxt;
  logic low_seen_r, low_seen_nxt;
  logic tx_pend_r, tx_pend_nxt;
  logic press_req_r, press_req_nxt;
  logic temp_req_r, temp_req_nxt;
  logic tick, fifo_in_ready, push;

  function automatic logic [PRESS_W_P-1:0] absdiff(input logic [PRESS_W_P-1:0] a,
                                                   input logic [PRESS_W_P-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [SEC_W-1:0] sample_period(input op_state_t st);
    case (st)
      ST_STORAGE: sample_period = STORE_SAMPLE_S;
      ST_INITIAL: sample_period = INIT_SAMPLE_S;
      ST_NORMAL: sample_period = NORM_PRESS_S;
      ST_BURST: sample_period = BURST_PERIOD_S;
      default: sample_period = STORE_SAMPLE_S;
    endcase
  endfunction

  assign tick = (pre_r == TICK_LAST);
  // a pending message waits here while the buffer is full
  assign push = tx_pend_r && fifo_in_ready;
  assign o_press_req = press_req_r;
  assign o_temp_req = temp_req_r;
  assign o_state = state_r;

  always_comb begin
    state_nxt = state_r;
    pre_nxt = tick ? '0 : pre_r + 1'b1;
    sec_cnt_nxt = sec_cnt_r;
    samp_cnt_nxt = samp_cnt_r;
    win_cnt_nxt = win_cnt_r;
    press_nxt = i_press_valid ? i_press_data : press_r;
    temp_nxt = i_temp_valid ? i_temp_data : temp_r;
    ref_nxt = ref_r;
    last_tx_nxt = push ? press_r : last_tx_r;
    parity_nxt = parity_r;
    low_seen_nxt = low_seen_r;
    tx_pend_nxt = push ? 1'b0 : tx_pend_r;
    press_req_nxt = 1'b0;
    temp_req_nxt = 1'b0;
    if (tick) begin
      if (sec_cnt_r != '1) begin
        sec_cnt_nxt = sec_cnt_r + 1'b1;
      end
      if (samp_cnt_r == '0) begin
        press_req_nxt = 1'b1;
        temp_req_nxt = parity_r;
        parity_nxt = ~parity_r;
        samp_cnt_nxt = sample_period(state_r) - 1'b1;
      end else begin
        samp_cnt_nxt = samp_cnt_r - 1'b1;
      end
    end
    case (state_r)
      ST_STORAGE: begin
        if (i_magnet) begin
          tx_pend_nxt = 1'b1;
        end
        if (i_press_valid && i_press_data > THR) begin
          state_nxt = ST_INITIAL;
          sec_cnt_nxt = '0;
          samp_cnt_nxt = '0;
          low_seen_nxt = 1'b0;
        end
      end
      ST_INITIAL: begin
        if (i_press_valid && i_press_data <= THR) begin
          low_seen_nxt = 1'b1;
        end
        if (tick && sec_cnt_r == INIT_WINDOW_S && press_r <= THR) begin
          state_nxt = ST_STORAGE;
          samp_cnt_nxt = STORE_SAMPLE_S - 1'b1;
        end else if (tick && sec_cnt_r > INIT_WINDOW_S) begin
          if (!low_seen_r) begin
            state_nxt = ST_NORMAL;
            samp_cnt_nxt = '0;
            win_cnt_nxt = '0;
            ref_nxt = press_r;
          end else begin
            // a dip inside the window restarts it rather than promoting
            sec_cnt_nxt = '0;
            // a dip landing on the restart tick still counts against the new window
            low_seen_nxt = i_press_valid && (i_press_data <= THR);
          end
        end
      end
      ST_NORMAL: begin
        if (tick) begin
          if (win_cnt_r == NORM_TX_S - 1'b1) begin
            tx_pend_nxt = 1'b1;
            win_cnt_nxt = '0;
            ref_nxt = press_r;
          end else begin
            win_cnt_nxt = win_cnt_r + 1'b1;
          end
        end
        if (i_press_valid) begin
          if (absdiff(i_press_data, last_tx_r) > TX_D) begin
            tx_pend_nxt = 1'b1;
          end
          if (absdiff(i_press_data, ref_r) > BURST_D) begin
            state_nxt = ST_BURST;
            sec_cnt_nxt = '0;
            samp_cnt_nxt = '0;
            ref_nxt = i_press_data;
            tx_pend_nxt = 1'b1;
          end
        end
      end
      ST_BURST: begin
        if (i_press_valid) begin
          tx_pend_nxt = 1'b1;
          if (absdiff(i_press_data, ref_r) > BURST_D) begin
            sec_cnt_nxt = '0;
            ref_nxt = i_press_data;
          end
        end
        if (tick && sec_cnt_r == BURST_DWELL_S - 1'b1 && sec_cnt_nxt != '0) begin
          state_nxt = ST_NORMAL;
          samp_cnt_nxt = '0;
          win_cnt_nxt = '0;
          ref_nxt = press_r;
        end
      end
      default: state_nxt = ST_STORAGE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= ST_STORAGE;
      pre_r <= '0;
      sec_cnt_r <= '0;
      samp_cnt_r <= STORE_SAMPLE_S - 9'h001;
      win_cnt_r <= '0;
      press_r <= '0;
      temp_r <= '0;
      ref_r <= '0;
      last_tx_r <= '0;
      parity_r <= 1'b0;
      low_seen_r <= 1'b0;
      tx_pend_r <= 1'b0;
      press_req_r <= 1'b0;
      temp_req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pre_r <= pre_nxt;
      sec_cnt_r <= sec_cnt_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      win_cnt_r <= win_cnt_nxt;
      press_r <= press_nxt;
      temp_r <= temp_nxt;
      ref_r <= ref_nxt;
      last_tx_r <= last_tx_nxt;
      parity_r <= parity_nxt;
      low_seen_r <= low_seen_nxt;
      tx_pend_r <= tx_pend_nxt;
      press_req_r <= press_req_nxt;
      temp_req_r <= temp_req_nxt;
    end
  end

  tx_fifo #(
    .WIDTH(MSG_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_tx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(tx_pend_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data({temp_r, press_r}),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence s_dwell_end;
    state_r == ST_BURST && tick && sec_cnt_r == BURST_DWELL_S - 1'b1 && !i_press_valid;
  endsequence

  sequence s_init_held;
    state_r == ST_INITIAL && tick && sec_cnt_r > INIT_WINDOW_S && !low_seen_r;
  endsequence

  property p_reset_storage;
    disable iff (1'b0) i_reset |=> state_r == ST_STORAGE;
  endproperty
  a_reset_storage: assert property (p_reset_storage) else $error("not in storage after reset");

  property p_storage_exit;
    state_r == ST_STORAGE && i_press_valid && i_press_data > THR |=> state_r == ST_INITIAL;
  endproperty
  a_storage_exit: assert property (p_storage_exit) else $error("storage did not leave on high pressure");

  property p_storage_quiet;
    $rose(tx_pend_r) && $past(state_r) == ST_STORAGE |-> $past(i_magnet);
  endproperty
  a_storage_quiet: assert property (p_storage_quiet) else $error("storage message without magnet");

  property p_init_back;
    state_r == ST_INITIAL && tick && sec_cnt_r == INIT_WINDOW_S && press_r <= THR |=> state_r == ST_STORAGE;
  endproperty
  a_init_back: assert property (p_init_back) else $error("initial did not return to storage");

  property p_init_promote;
    s_init_held |=> state_r == ST_NORMAL;
  endproperty
  a_init_promote: assert property (p_init_promote) else $error("initial did not reach normal");

  property p_no_return;
    state_r inside {ST_NORMAL, ST_BURST} |=> state_r inside {ST_NORMAL, ST_BURST};
  endproperty
  a_no_return: assert property (p_no_return) else $error("left normal or burst group");

  property p_change_tx;
    state_r == ST_NORMAL && i_press_valid && absdiff(i_press_data, last_tx_r) > TX_D |=> tx_pend_r;
  endproperty
  a_change_tx: assert property (p_change_tx) else $error("pressure change not sent");

  property p_burst_entry;
    state_r == ST_NORMAL && i_press_valid && absdiff(i_press_data, ref_r) > BURST_D
      |=> state_r == ST_BURST && sec_cnt_r == '0;
  endproperty
  a_burst_entry: assert property (p_burst_entry) else $error("large change did not enter burst");

  property p_dwell_end;
    s_dwell_end |=> state_r == ST_NORMAL;
  endproperty
  a_dwell_end: assert property (p_dwell_end) else $error("burst did not end after dwell");

  property p_temp_pairs;
    o_temp_req |-> o_press_req ##1 !o_temp_req;
  endproperty
  a_temp_pairs: assert property (p_temp_pairs) else $error("temperature request without pressure");
endmodule

// File: dv/rx_model.sv
// receiver model that takes messages from the sequencer
`timescale 1ns/10ps
module rx_model
  import wheel_seq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_stall,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [PRESS_W+TEMP_W-1:0] i_tx_data,
  output logic [15:0] o_count,
  output logic [PRESS_W+TEMP_W-1:0] o_last
);
  // ready drops only when a scenario stalls the radio
  assign o_tx_ready = !i_stall;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_count <= 16'h0000;
      o_last <= '0;
    end else if (i_tx_valid && o_tx_ready) begin
      o_count <= o_count + 16'h0001;
      o_last <= i_tx_data;
    end
  end
endmodule

// File: dv/wheel_state_seq_bench.sv
// self-checking bench for the wheel sensor state sequencer
`timescale 1ns/10ps
module wheel_state_seq_bench;
  import wheel_seq_pkg::*;
  // short tick keeps the 240 s intervals affordable
  localparam int TK = 4;
  logic i_ref_clk, i_reset, i_press_valid, i_temp_valid, i_magnet, stall;
  logic pv = 1'b0;
  logic tv = 1'b0;
  logic [11:0] i_press_data;
  logic [7:0] i_temp_data;
  logic o_press_req, o_temp_req, o_tx_valid, tx_ready;
  logic [19:0] o_tx_data, last;
  logic [15:0] count;
  op_state_t o_state;
  logic was_norm = 1'b0;
  logic left_norm = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;

  wheel_state_seq #(.TICK_CYCLES_P(TK)) u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .o_press_req(o_press_req), .i_press_valid(i_press_valid), .i_press_data(i_press_data),
    .o_temp_req(o_temp_req), .i_temp_valid(i_temp_valid), .i_temp_data(i_temp_data),
    .i_magnet(i_magnet), .o_tx_valid(o_tx_valid), .i_tx_ready(tx_ready), .o_tx_data(o_tx_data),
    .o_state(o_state));
  rx_model u_rx (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_stall(stall), .i_tx_valid(o_tx_valid),
    .o_tx_ready(tx_ready), .i_tx_data(o_tx_data), .o_count(count), .o_last(last));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // sensor front end answers one cycle after each request; requests read once settled
  always @(posedge i_ref_clk) begin
    #1;
    i_press_valid = pv;
    i_temp_valid = tv;
    pv = o_press_req;
    tv = o_temp_req;
  end

  // once normal, storage or initial must never show again
  always @(posedge i_ref_clk) begin
    if (o_state === ST_NORMAL) was_norm <= 1'b1;
    if (was_norm && (o_state === ST_STORAGE || o_state === ST_INITIAL)) left_norm <= 1'b1;
  end

  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wait_state(input op_state_t st, input int lim, output int t);
    t = 0;
    while (o_state !== st && t < lim) begin
      cyc(1);
      t++;
    end
  endtask

  task automatic next_req(output int t);
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (o_press_req !== 1'b1 && t < 2000);
  endtask

  task automatic wait_msg(input int lim, output int t);
    logic [15:0] c0;
    c0 = count;
    t = 0;
    while (count === c0 && t < lim) begin
      cyc(1);
      t++;
    end
  endtask

  task automatic t_storage();
    int t;
    chk("reset state", ST_STORAGE, o_state);
    chk("reset tx valid", 0, o_tx_valid);
    next_req(t);
    next_req(t);
    chk("storage sample gap", 240 * TK, t);
    cyc(3);
    chk("storage stays low", ST_STORAGE, o_state);
    chk("storage silent", 0, count);
    i_magnet = 1'b1;
    cyc(1);
    i_magnet = 1'b0;
    cyc(5);
    chk("magnet msg count", 1, count);
    chk("magnet msg data", {8'h2a, 12'h1f4}, last);
    i_press_data = 12'h258;
    wait_state(ST_INITIAL, 250 * TK, t);
    chk("storage to initial", ST_INITIAL, o_state);
  endtask

  task automatic t_initial();
    int t;
    next_req(t);
    next_req(t);
    chk("initial sample gap", TK, t);
    i_press_data = 12'h1f4;
    wait_state(ST_STORAGE, 125 * TK, t);
    chk("initial low to storage", ST_STORAGE, o_state);
    i_press_data = 12'h258;
    wait_state(ST_INITIAL, 250 * TK, t);
    wait_state(ST_NORMAL, 130 * TK, t);
    chk("initial to normal", ST_NORMAL, o_state);
    chk("initial dwell long", 1, t >= 119 * TK);
  endtask

  task automatic t_normal();
    int t;
    int nt;
    // let any entry burst run out before timing the normal cadence
    cyc(30 * TK);
    wait_state(ST_NORMAL, 30 * TK, t);
    next_req(t);
    nt = 0;
    for (int i = 0; i < 4; i++) begin
      next_req(t);
      chk("normal press gap", 3 * TK, t);
      nt += int'(o_temp_req === 1'b1);
    end
    chk("temp every second sample", 2, nt);
    wait_msg(250 * TK, t);
    wait_msg(250 * TK, t);
    wait_msg(250 * TK, t);
    chk("periodic gap", 240 * TK, t);
    i_press_data = 12'h26c;
    wait_msg(4 * TK, t);
    chk("small change sent", 1, t < 4 * TK);
    chk("small change data", {8'h2a, 12'h26c}, last);
    chk("small change no burst", ST_NORMAL, o_state);
  endtask

  task automatic t_burst();
    int t;
    logic [15:0] c0;
    i_press_data = 12'h2d0;
    wait_state(ST_BURST, 4 * TK, t);
    chk("big change burst", ST_BURST, o_state);
    stall = 1'b1;
    c0 = count;
    cyc(7 * TK);
    chk("stalled no pop", c0, count);
    chk("full fifo holds", 1, o_tx_valid);
    stall = 1'b0;
    cyc(8);
    wait_msg(2 * TK, t);
    c0 = count;
    cyc(5 * TK - 2);
    chk("burst msg rate", c0 + 16'h0004, count);
    i_press_data = 12'h334;
    wait_state(ST_BURST, 1, t);
    cyc(2 * TK);
    wait_state(ST_NORMAL, 24 * TK, t);
    chk("burst back to normal", ST_NORMAL, o_state);
    chk("dwell restarted", 1, t >= 17 * TK);
    chk("never left normal", 0, left_norm);
  endtask

  initial begin
    i_reset = 1'b1;
    i_press_data = 12'h1f4;
    i_temp_data = 8'h2a;
    i_magnet = 1'b0;
    stall = 1'b0;
    cyc(10);
    i_reset = 1'b0;
    cyc(1);
    t_storage();
    t_initial();
    t_normal();
    t_burst();
    end_sim();
  end

  // whole run needs about 8k cycles
  initial begin
    #4_000_000;
    n_errors++;
    end_sim();
  end
endmodule

// File: pkg/wheel_seq_pkg.sv
// constants and types shared by the wheel sensor state sequencer
package wheel_seq_pkg;
  // core clock and one-second timebase
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int PRE_W = 24;

  // reading widths; pressure lsb is 0.1 psi
  localparam int PRESS_W = 12;
  localparam int TEMP_W = 8;
  localparam int PRESS_LSB_DPSI = 1;

  // pressure thresholds in 0.1 psi units
  localparam logic [11:0] STORE_THR_DPSI = 12'h226;
  localparam logic [11:0] TX_DELTA_DPSI = 12'h00f;
  localparam logic [11:0] BURST_DELTA_DPSI = 12'h050;

  // timing in seconds, counted on the one-second tick
  localparam int SEC_W = 9;
  localparam logic [8:0] STORE_SAMPLE_S = 9'h0f0;
  localparam logic [8:0] INIT_SAMPLE_S = 9'h001;
  localparam logic [8:0] INIT_WINDOW_S = 9'h078;
  localparam logic [8:0] NORM_PRESS_S = 9'h003;
  localparam logic [8:0] NORM_TEMP_S = 9'h006;
  localparam logic [8:0] NORM_TX_S = 9'h0f0;
  localparam logic [8:0] BURST_WINDOW_S = 9'h0f0;
  localparam logic [8:0] BURST_PERIOD_S = 9'h001;
  localparam logic [8:0] BURST_DWELL_S = 9'h014;

  // transmit buffer
  localparam int TX_FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    ST_STORAGE,
    ST_INITIAL,
    ST_NORMAL,
    ST_BURST
  } op_state_t;
endpackage
